// ==== bench/dma_block_transfer_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module dma_block_transfer_asserts
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        xferAck,
   input wire logic        memRead,
   input wire logic        memWrite,
   input wire logic [23:0] memAddr,
   input wire logic        memReady
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // handshake and transfer sequencing checks
   ack_pulse_a: assert property (xferAck |=> !xferAck)
      else $error("accept pulse longer than one cycle");
   ack_read_a: assert property (xferAck |-> memRead)
      else $error("accept without read");
   rd_hold_a: assert property (memRead && !memReady |=> memRead && $stable(memAddr))
      else $error("read dropped early");
   wr_hold_a: assert property (memWrite && !memReady |=> memWrite && $stable(memAddr))
      else $error("write dropped early");
   rd_then_wr_a: assert property (memRead && memReady |=> memWrite && !memRead)
      else $error("no write after read");
   no_accept_busy_a: assert property (memWrite |-> !xferAck)
      else $error("accept during block");
   apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   err_with_ready_a: assert property (pslverr |-> pready && psel)
      else $error("error without ready");
endmodule
bind dma_block_transfer dma_block_transfer_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .xferAck(xferAck),
   .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr), .memReady(memReady));
`default_nettype wire

// ==== bench/dma_block_transfer_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dma_block_defines.vh"
module dma_block_transfer_tb_top;
   logic        ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, xferReq = 1'h0, errv;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdv, memRdata, memWdata;
   logic [23:0] memAddr;
   logic [3:0]  lag = 4'h0;
   logic        pready, pslverr, xferAck, memRead, memWrite, memReady, irq;
   int          n_fail = 0, total_checks = 0;
   // free running clock
   always #25 ref_clk = ~ref_clk;
   dma_block_transfer u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xferReq(xferReq), .xferAck(xferAck), .memRead(memRead),
      .memWrite(memWrite), .memAddr(memAddr), .memReady(memReady), .memRdata(memRdata),
      .memWdata(memWdata), .irq(irq));
   dma_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .memRead(memRead),
      .memWrite(memWrite), .memAddr(memAddr), .lag(lag), .memReady(memReady),
      .memRdata(memRdata));
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; held until pready is sampled high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do @(posedge ref_clk); while (pready !== 1'h1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function logic [23:0] stp(input logic [23:0] a, input logic [1:0] m);
      return (m == `STEP_INC) ? a + 24'h1 : (m == `STEP_DEC) ? a - 24'h1 : a;
   endfunction
   // program a channel, run every block and judge each transfer
   task run(input logic [1:0] sm, dm, input logic ad, input logic [7:0] sz,
            input logic [15:0] nb, input logic [1:0] mask);
      logic [23:0] s, d, s0, d0;
      s = 24'h001000;
      d = 24'h00F000;
      apb(1'h1, `OFS_SRC_ADDR, {8'h0, s});
      apb(1'h1, `OFS_DST_ADDR, {8'h0, d});
      apb(1'h1, `OFS_SIZE_CNT, {24'h0, sz});
      apb(1'h1, `OFS_SIZE_INIT, {24'h0, sz});
      apb(1'h1, `OFS_BLK_COUNT, {16'h0, nb});
      apb(1'h1, `OFS_IRQ_MASK, {30'h0, mask});
      apb(1'h1, `OFS_CONTROL, {26'h0, dm, sm, ad, 1'h1});
      repeat (nb)
      begin
         s0 = s;
         d0 = d;
         @(posedge ref_clk);
         xferReq <= 1'h1;
         do @(negedge ref_clk); while (xferAck !== 1'h1);
         @(posedge ref_clk);
         xferReq <= 1'h0;
         repeat (sz)
         begin
            do @(negedge ref_clk); while (!(memRead && memReady));
            chk({8'h0, memAddr}, {8'h0, s}, "read addr");
            do @(negedge ref_clk); while (!(memWrite && memReady));
            chk({8'h0, memAddr}, {8'h0, d}, "write addr");
            chk(memWdata, {8'h5A, s}, "write data");
            s = stp(s, sm);
            d = stp(d, dm);
         end
         if (ad)
            d = d0;
         else
            s = s0;
         repeat (3) @(negedge ref_clk);
         chk({31'h0, memRead}, 32'h0, "idle after block");
         apb(1'h0, `OFS_SRC_ADDR, 32'h0);
         chk(rdv, {8'h0, s}, "source");
         apb(1'h0, `OFS_DST_ADDR, 32'h0);
         chk(rdv, {8'h0, d}, "destination");
      end
      apb(1'h0, `OFS_BLK_COUNT, 32'h0);
      chk(rdv, 32'h0, "block count");
      apb(1'h0, `OFS_SIZE_CNT, 32'h0);
      chk(rdv, {24'h0, sz}, "size reload");
      apb(1'h0, `OFS_CONTROL, 32'h0);
      chk({31'h0, rdv[`CTL_ENABLE]}, 32'h0, "enable");
      chk({31'h0, irq}, {31'h0, |mask}, "irq");
      apb(1'h0, `OFS_STATUS, 32'h0);
      chk({30'h0, rdv[1:0]}, 32'h3, "status");
      repeat (3) @(posedge ref_clk);
      // request after the last block is refused
      xferReq <= 1'h1;
      repeat (6) @(negedge ref_clk);
      chk({30'h0, irq, memRead}, 32'h0, "refused");
      @(posedge ref_clk);
      xferReq <= 1'h0;
   endtask
   task results;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'h1;
      apb(1'h0, `OFS_CONTROL, 32'h0);
      chk(rdv, 32'h0, "control reset");
      apb(1'h0, 12'h020, 32'h0);
      chk({31'h0, errv}, 32'h1, "unmapped");
      run(`STEP_INC, `STEP_INC, 1'h0, 8'h03, 16'h0002, 2'h3);
      lag <= 4'h3;
      run(`STEP_DEC, `STEP_FIXED, 1'h1, 8'h02, 16'h0002, 2'h0);
      run(`STEP_FIXED, `STEP_DEC, 1'h1, 8'h01, 16'h0001, 2'h2);
      results;
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      results;
   end
endmodule
`default_nettype wire

// ==== bench/dma_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dma_mem_model
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        memRead,
   input  wire logic        memWrite,
   input  wire logic [23:0] memAddr,
   input  wire logic [3:0]  lag,
   output var  logic        memReady,
   output var  logic [31:0] memRdata
);
   logic [3:0] waitCnt;
   // answers after lag cycles; data toggles when not valid so stale data never matches
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         waitCnt <= 4'h0;
         memReady <= 1'h0;
         memRdata <= 32'h0;
      end
      else
      begin
         memReady <= 1'h0;
         memRdata <= ~memRdata;
         if ((memRead || memWrite) && !memReady)
         begin
            waitCnt <= (waitCnt >= lag) ? 4'h0 : waitCnt + 4'h1;
            memReady <= (waitCnt >= lag);
            if (memRead && waitCnt >= lag)
               memRdata <= {8'h5A, memAddr};
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/dma_block_defines.vh ====
`ifndef DMA_BLOCK_DEFINES_VH
`define DMA_BLOCK_DEFINES_VH

// register byte offsets
`define OFS_SRC_ADDR   12'h000
`define OFS_DST_ADDR   12'h004
`define OFS_SIZE_CNT   12'h008
`define OFS_SIZE_INIT  12'h00C
`define OFS_BLK_COUNT  12'h010
`define OFS_CONTROL    12'h014
`define OFS_STATUS     12'h018
`define OFS_IRQ_MASK   12'h01C

// control register fields
`define CTL_ENABLE     0
`define CTL_AREA_DST   1
`define CTL_SRC_MODE   3:2
`define CTL_DST_MODE   5:4

// address step modes
`define STEP_FIXED     2'h0
`define STEP_INC       2'h1
`define STEP_DEC       2'h2

// status bits
`define ST_BLOCK_DONE  0
`define ST_XFER_END    1
`define ST_BUSY        2

`define CTL_RESET      6'h00
`define ADDR_RESET     24'h000000
`define SIZE_ZERO      8'h00
`define CNT_ZERO       16'h0000

`endif

// ==== verilog/dma_block_transfer.v ====
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dma_block_defines.vh"

// one address stepper; any mode other than up or down holds the address
module dma_addr_step
#(
   parameter ADDR_W = 24
)
(
   input  wire [ADDR_W-1:0] addrIn,
   input  wire [1:0]        mode,
   output reg  [ADDR_W-1:0] addrOut
);

   // wraps at the ends of the space, no saturation
   always @*
   begin
      case (mode)
         `STEP_INC: addrOut = addrIn + {{(ADDR_W-1){1'b0}}, 1'b1};
         `STEP_DEC: addrOut = addrIn - {{(ADDR_W-1){1'b0}}, 1'b1};
         default:   addrOut = addrIn;
      endcase
   end

endmodule

module dma_block_transfer
#(
   parameter ADDR_W = 24,
   parameter SIZE_W = 8,
   parameter CNT_W  = 16
)
(
   input  wire              ref_clk,
   input  wire              rst_n,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire              xferReq,
   output reg               xferAck,
   output reg               memRead,
   output reg               memWrite,
   output reg  [ADDR_W-1:0] memAddr,
   input  wire              memReady,
   input  wire [31:0]       memRdata,
   output reg  [31:0]       memWdata,
   output reg               irq
);

   localparam S_IDLE  = 2'h0;
   localparam S_READ  = 2'h1;
   localparam S_WRITE = 2'h2;
   localparam S_STEP  = 2'h3;

   // last-unit compare values, sized to their counters
   localparam [SIZE_W-1:0] SIZE_ONE = {{(SIZE_W-1){1'b0}}, 1'b1};
   localparam [CNT_W-1:0]  CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

   reg [ADDR_W-1:0] srcAddr_ff;
   reg [ADDR_W-1:0] dstAddr_ff;
   reg [ADDR_W-1:0] areaStart_ff;
   reg [SIZE_W-1:0] sizeCnt_ff;
   reg [SIZE_W-1:0] sizeInit_ff;
   reg [CNT_W-1:0]  blkCount_ff;
   reg [5:0]        ctl_ff;
   reg [1:0]        status_ff;
   reg [1:0]        mask_ff;
   reg [1:0]        state_ff;
   reg              readyOut_ff;
   reg              errOut_ff;

   reg [31:0]       nxt_prdata;
   reg [1:0]        nxt_status;
   reg              blockDone;
   reg              xferEnd;
   wire [ADDR_W-1:0] srcNext;
   wire [ADDR_W-1:0] dstNext;

   // register selects, used by the error path and the status clear; read and write paths decode paddr in their own case
   wire selSrc   = (paddr == `OFS_SRC_ADDR);
   wire selDst   = (paddr == `OFS_DST_ADDR);
   wire selSzCnt = (paddr == `OFS_SIZE_CNT);
   wire selSzIni = (paddr == `OFS_SIZE_INIT);
   wire selBlk   = (paddr == `OFS_BLK_COUNT);
   wire selCtl   = (paddr == `OFS_CONTROL);
   wire selStat  = (paddr == `OFS_STATUS);
   wire selMask  = (paddr == `OFS_IRQ_MASK);
   wire mapped   = selSrc | selDst | selSzCnt | selSzIni | selBlk | selCtl | selStat | selMask;

   // first access cycle; the answer follows one cycle later
   wire apbFirst = psel & penable & ~readyOut_ff;
   wire apbWr    = psel & penable & pwrite & readyOut_ff;
   wire apbRd    = psel & penable & ~pwrite & readyOut_ff;
   wire busy     = (state_ff != S_IDLE);
   wire areaDst  = ctl_ff[`CTL_AREA_DST];

   // apb answer next values
   wire nxt_ready = apbFirst;
   wire nxt_err   = apbFirst & ~mapped;

   // end of block and end of transfer, seen in the step cycle
   wire lastXfer  = (sizeCnt_ff == SIZE_ONE);
   wire lastBlock = (blkCount_ff == CNT_ONE);

   // a request is only taken in idle with work left
   wire canAccept = ctl_ff[`CTL_ENABLE] & xferReq & (blkCount_ff != `CNT_ZERO)
                    & (sizeCnt_ff != `SIZE_ZERO);

   // interrupt next value, one cycle behind the status bits
   wire nxt_irq = |(status_ff & mask_ff);

   // one wait state per access keeps prdata registered
   assign pready  = readyOut_ff;
   assign pslverr = errOut_ff;

   // independent steppers for source and destination
   dma_addr_step
   #(
      .ADDR_W (ADDR_W)
   )
   u_src_step
   (
      .addrIn  (srcAddr_ff),
      .mode    (ctl_ff[`CTL_SRC_MODE]),
      .addrOut (srcNext)
   );

   dma_addr_step
   #(
      .ADDR_W (ADDR_W)
   )
   u_dst_step
   (
      .addrIn  (dstAddr_ff),
      .mode    (ctl_ff[`CTL_DST_MODE]),
      .addrOut (dstNext)
   );

   // apb ready and error, answer on second access cycle
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         readyOut_ff <= 1'b0;
         errOut_ff   <= 1'b0;
      end
      else
      begin
         readyOut_ff <= nxt_ready;
         errOut_ff   <= nxt_err;
      end
   end

   // read data mux; loaded in the first access cycle only
   always @*
   begin
      nxt_prdata = prdata;
      if (apbFirst & ~pwrite)
      begin
         case (paddr)
            `OFS_SRC_ADDR:  nxt_prdata = {{(32-ADDR_W){1'b0}}, srcAddr_ff};
            `OFS_DST_ADDR:  nxt_prdata = {{(32-ADDR_W){1'b0}}, dstAddr_ff};
            `OFS_SIZE_CNT:  nxt_prdata = {{(32-SIZE_W){1'b0}}, sizeCnt_ff};
            `OFS_SIZE_INIT: nxt_prdata = {{(32-SIZE_W){1'b0}}, sizeInit_ff};
            `OFS_BLK_COUNT: nxt_prdata = {{(32-CNT_W){1'b0}}, blkCount_ff};
            `OFS_CONTROL:   nxt_prdata = {26'h0000000, ctl_ff};
            `OFS_STATUS:    nxt_prdata = {29'h0000000, busy, status_ff};
            `OFS_IRQ_MASK:  nxt_prdata = {30'h0000000, mask_ff};
            default:        nxt_prdata = 32'h00000000;
         endcase
      end
   end

   // read data register, stands through the answer cycle
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h00000000;
      else
         prdata <= nxt_prdata;
   end

   // channel engine and registers
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         srcAddr_ff   <= `ADDR_RESET;
         dstAddr_ff   <= `ADDR_RESET;
         areaStart_ff <= `ADDR_RESET;
         sizeCnt_ff   <= `SIZE_ZERO;
         sizeInit_ff  <= `SIZE_ZERO;
         blkCount_ff  <= `CNT_ZERO;
         ctl_ff       <= `CTL_RESET;
         mask_ff      <= 2'h0;
         state_ff     <= S_IDLE;
         memRead      <= 1'b0;
         memWrite     <= 1'b0;
         memAddr      <= `ADDR_RESET;
         memWdata     <= 32'h00000000;
         xferAck      <= 1'b0;
         blockDone    <= 1'b0;
         xferEnd      <= 1'b0;
      end
      else
      begin
         xferAck   <= 1'b0;
         blockDone <= 1'b0;
         xferEnd   <= 1'b0;
         // software writes, ignored for engine registers while busy
         if (apbWr)
         begin
            case (paddr)
               `OFS_SRC_ADDR:  if (!busy) srcAddr_ff <= pwdata[ADDR_W-1:0];
               `OFS_DST_ADDR:  if (!busy) dstAddr_ff <= pwdata[ADDR_W-1:0];
               `OFS_SIZE_CNT:  if (!busy) sizeCnt_ff <= pwdata[SIZE_W-1:0];
               `OFS_SIZE_INIT: if (!busy) sizeInit_ff <= pwdata[SIZE_W-1:0];
               `OFS_BLK_COUNT: if (!busy) blkCount_ff <= pwdata[CNT_W-1:0];
               `OFS_CONTROL:   ctl_ff <= pwdata[5:0];
               `OFS_IRQ_MASK:  mask_ff <= pwdata[1:0];
               default:        ;
            endcase
         end
         case (state_ff)
            S_IDLE:
            begin
               if (canAccept)
               begin
                  xferAck      <= 1'b1;
                  areaStart_ff <= areaDst ? dstAddr_ff : srcAddr_ff;
                  memAddr      <= srcAddr_ff;
                  memRead      <= 1'b1;
                  state_ff     <= S_READ;
               end
            end
            S_READ:
            begin
               if (memReady)
               begin
                  memRead  <= 1'b0;
                  memWdata <= memRdata;
                  memAddr  <= dstAddr_ff;
                  memWrite <= 1'b1;
                  state_ff <= S_WRITE;
               end
            end
            S_WRITE:
            begin
               if (memWrite && memReady)
               begin
                  memWrite <= 1'b0;
                  state_ff <= S_STEP;
               end
            end
            S_STEP:
            begin
               // per transfer size count
               // reload at one, so a zero count never reaches the engine
               if (lastXfer)
               begin
                  sizeCnt_ff  <= sizeInit_ff;
                  blockDone   <= 1'b1;
                  blkCount_ff <= blkCount_ff - CNT_ONE;
                  if (lastBlock)
                  begin
                     xferEnd <= 1'b1;
                     ctl_ff[`CTL_ENABLE] <= 1'b0;
                  end
                  if (areaDst)
                  begin
                     dstAddr_ff <= areaStart_ff;
                     srcAddr_ff <= srcNext;
                  end
                  else
                  begin
                     srcAddr_ff <= areaStart_ff;
                     dstAddr_ff <= dstNext;
                  end
                  state_ff <= S_IDLE;
               end
               else
               begin
                  sizeCnt_ff <= sizeCnt_ff - SIZE_ONE;
                  srcAddr_ff <= srcNext;
                  dstAddr_ff <= dstNext;
                  memAddr    <= srcNext;
                  memRead    <= 1'b1;
                  state_ff   <= S_READ;
               end
            end
            default:
               state_ff <= S_IDLE;
         endcase
      end
   end

   // sticky status next value; an event in the clearing cycle survives
   always @*
   begin
      if (apbRd && selStat)
         nxt_status = {xferEnd, blockDone};
      else
         nxt_status = status_ff | {xferEnd, blockDone};
   end

   // sticky status register
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         status_ff <= 2'h0;
      else
         status_ff <= nxt_status;
   end

   // level interrupt from registered state
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= nxt_irq;
   end

endmodule
`default_nettype wire
